/* srb_pkg.sv */
// Constants, state encoding and state record for the serial receive block.
// Assumes one 100 MHz clock, which is also the oscillator that the baud divider divides.
package srb_pkg;
    localparam int ADR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_RX_CTRL = 8'h00;
    localparam logic [7:0] OFS_TX_CTRL = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_RX_DATA = 8'h0C;
    localparam logic [7:0] OFS_IRQ_ST = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    // receive_control_status fields
    localparam int RC_SPEN = 7;
    localparam int RC_NINE = 6;
    localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RC_ADDRESS_DETECT_ENABLE = 3;
    localparam int RC_FRAMING_ERROR_FLAG = 2;
    localparam int RC_OVERRUN_ERROR_FLAG = 1;
    localparam int RC_NINTH = 0;
    // transmit_control_register fields
    localparam int TC_MASTER = 7;
    localparam int TC_TXON = 5;
    localparam int TC_SYNC = 4;
    localparam int TC_HS = 2;
    // Interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_FRAMING_ERROR_FLAG = 2;
    // Prescaler last counts: 16 oversamples times 4 or times 1
    localparam logic [1:0] PRE_LOW_LAST = 2'h3;
    localparam logic [1:0] PRE_FAST_LAST = 2'h0;
    localparam logic [3:0] OS_MID = 4'h7;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] BITS_LAST8 = 4'h7;
    localparam logic [3:0] BITS_LAST9 = 4'h8;
    localparam logic [1:0] PH_RISE = 2'h1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b11,
        ST_STOP = 2'b10
    } srb_state_t;
    typedef struct packed {
        logic rx1;
        logic rx2;
        logic ck1;
        logic ck2;
        logic ck_prev;
        logic spen;
        logic nine;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic master;
        logic txon;
        logic sync;
        logic hs;
        logic [7:0] divisor;
        logic [1:0] pre;
        logic [7:0] baud_generator;
        logic [1:0] ph;
        logic ck_out;
        srb_state_t st;
        logic [3:0] os;
        logic [3:0] bits;
        logic [8:0] sh;
        logic [7:0] rbuf;
        logic ninth;
        logic full;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic ack;
        logic [7:0] dat;
    } srb_regs_t;
    localparam srb_regs_t SRB_RST = '0;
endpackage

/* srb_serial_rx.sv */
// Receive control, status and baud generator of the serial port, behind a classic Wishbone slave.
// Assumes data and clock pins are asynchronous to ref_clk; the bus master is on ref_clk.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module srb_serial_rx
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [srb_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial line
    input wire logic rx_in,
    input wire logic ck_in,
    output logic ck_out,
    output logic ck_oe_n,
    // Status
    output logic tx_active,
    output logic irq
);
    srb_pkg::srb_regs_t s;
    srb_pkg::srb_regs_t n;
    logic acc;
    logic wr;
    logic rd;
    logic div_wr;
    logic continuous_receive_enable_clr;
    logic pop;
    logic pre_tick;
    logic brg_tick;
    logic master;
    logic samp;
    logic en_a;
    logic en_s;
    logic done;
    logic new_framing_error_flag;
    logic accept;
    logic [3:0] last_bit;
    logic [7:0] char;
    logic nbit;
    logic [srb_pkg::IRQ_W-1:0] ev;
    logic [srb_pkg::IRQ_W-1:0] w1c;
    logic [7:0] rdata;

    always_comb
    begin
        n = s;
        n.rx1 = rx_in;
        n.rx2 = s.rx1;
        n.ck1 = ck_in;
        n.ck2 = s.ck1;
        n.ck_prev = s.ck2;
        // Write and read act at the edge where ack is seen high
        acc = wb_cyc_i & wb_stb_i & s.ack;
        wr = acc & wb_we_i & wb_sel_i[0];
        rd = acc & ~wb_we_i;
        n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
        div_wr = wr && (wb_adr_i == srb_pkg::OFS_BAUD);
        continuous_receive_enable_clr = wr && (wb_adr_i == srb_pkg::OFS_RX_CTRL) && !wb_dat_i[srb_pkg::RC_CONTINUOUS_RECEIVE_ENABLE] && s.continuous_receive_enable;
        pop = rd && (wb_adr_i == srb_pkg::OFS_RX_DATA);
        w1c = '0;
        ev = '0;
        done = 1'b0;
        new_framing_error_flag = 1'b0;
        brg_tick = 1'b0;

        // Software writes go first so hardware updates below win
        if (wr)
        begin
            case (wb_adr_i)
                srb_pkg::OFS_RX_CTRL:
                begin
                    n.spen = wb_dat_i[srb_pkg::RC_SPEN];
                    n.nine = wb_dat_i[srb_pkg::RC_NINE];
                    n.single_receive_enable = wb_dat_i[srb_pkg::RC_SINGLE_RECEIVE_ENABLE];
                    n.continuous_receive_enable = wb_dat_i[srb_pkg::RC_CONTINUOUS_RECEIVE_ENABLE];
                    n.address_detect_enable = wb_dat_i[srb_pkg::RC_ADDRESS_DETECT_ENABLE];
                end
                srb_pkg::OFS_TX_CTRL:
                begin
                    n.master = wb_dat_i[srb_pkg::TC_MASTER];
                    n.txon = wb_dat_i[srb_pkg::TC_TXON];
                    n.sync = wb_dat_i[srb_pkg::TC_SYNC];
                    n.hs = wb_dat_i[srb_pkg::TC_HS];
                end
                srb_pkg::OFS_BAUD: n.divisor = wb_dat_i[7:0];
                srb_pkg::OFS_IRQ_ST: w1c = wb_dat_i[srb_pkg::IRQ_W-1:0];
                srb_pkg::OFS_IRQ_MASK: n.irq_mask = wb_dat_i[srb_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end

        // Prescaler then 8-bit reload timer; sync mode never looks at hs
        pre_tick = (s.pre == ((!s.sync && !s.hs) ? srb_pkg::PRE_LOW_LAST : srb_pkg::PRE_FAST_LAST));
        if (div_wr)
        begin
            n.pre = 2'h0;
            n.baud_generator = 8'h00;
        end
        else
        begin
            n.pre = pre_tick ? 2'h0 : s.pre + 2'h1;
            if (pre_tick)
            begin
                if (s.baud_generator == 8'h00)
                begin
                    n.baud_generator = s.divisor;
                    brg_tick = 1'b1;
                end
                else
                begin
                    n.baud_generator = s.baud_generator - 8'h01;
                end
            end
        end

        // Master shift clock: four timer periods per bit
        master = s.sync & s.master;
        if (brg_tick)
        begin
            n.ph = s.ph + 2'h1;
        end
        n.ck_out = master & s.ph[1];
        // Slave samples the pin clock, never the divider
        samp = master ? (brg_tick && s.ph == srb_pkg::PH_RISE) : (s.ck2 & ~s.ck_prev);
        // Overrun holds reception off, as the buffer cannot take more
        en_a = s.spen & ~s.sync & s.continuous_receive_enable & ~s.overrun_error_flag;
        en_s = s.spen & s.sync & (s.continuous_receive_enable | s.single_receive_enable) & ~s.overrun_error_flag;
        last_bit = s.nine ? srb_pkg::BITS_LAST9 : srb_pkg::BITS_LAST8;

        if (s.st != srb_pkg::ST_IDLE && !(en_a || en_s))
        begin
            n.st = srb_pkg::ST_IDLE;
        end
        else
        begin
            case (s.st)
                srb_pkg::ST_IDLE:
                begin
                    n.bits = 4'h0;
                    // A low stop bit leaves os set: no new start until the line has gone high
                    if (s.rx2 || en_s)
                    begin
                        n.os = 4'h0;
                    end
                    if (en_a && !s.rx2 && s.os == 4'h0)
                    begin
                        n.st = srb_pkg::ST_START;
                    end
                    else if (en_s)
                    begin
                        n.st = srb_pkg::ST_DATA;
                    end
                end
                srb_pkg::ST_START:
                begin
                    if (brg_tick)
                    begin
                        n.os = s.os + 4'h1;
                        if (s.os == srb_pkg::OS_MID)
                        begin
                            // Short low pulse is taken as noise
                            n.os = 4'h0;
                            n.st = s.rx2 ? srb_pkg::ST_IDLE : srb_pkg::ST_DATA;
                        end
                    end
                end
                srb_pkg::ST_DATA:
                begin
                    if (brg_tick)
                    begin
                        n.os = s.os + 4'h1;
                    end
                    if (s.sync ? samp : (brg_tick && s.os == srb_pkg::OS_LAST))
                    begin
                        n.sh = {s.rx2, s.sh[8:1]};
                        n.bits = s.bits + 4'h1;
                        if (s.bits == last_bit)
                        begin
                            n.st = s.sync ? srb_pkg::ST_IDLE : srb_pkg::ST_STOP;
                            done = s.sync;
                        end
                    end
                end
                srb_pkg::ST_STOP:
                begin
                    if (brg_tick)
                    begin
                        n.os = s.os + 4'h1;
                        if (s.os == srb_pkg::OS_LAST)
                        begin
                            done = 1'b1;
                            new_framing_error_flag = ~s.rx2;
                            n.st = srb_pkg::ST_IDLE;
                            if (!s.rx2)
                            begin
                                n.os = srb_pkg::OS_LAST;
                            end
                        end
                    end
                end
                default: n.st = srb_pkg::ST_IDLE;
            endcase
        end

        char = s.nine ? n.sh[7:0] : n.sh[8:1];
        nbit = s.nine & n.sh[8];
        // Single receive ends after one character unless continuous is on
        if (done && s.sync && !s.continuous_receive_enable)
        begin
            n.single_receive_enable = 1'b0;
        end
        accept = done && !(s.nine && s.address_detect_enable && !nbit);
        if (pop)
        begin
            n.full = 1'b0;
        end
        if (continuous_receive_enable_clr)
        begin
            n.overrun_error_flag = 1'b0;
        end
        if (accept)
        begin
            if (s.full && !pop)
            begin
                n.overrun_error_flag = 1'b1;
                ev[srb_pkg::IRQ_OVR] = 1'b1;
            end
            else
            begin
                n.rbuf = char;
                n.ninth = nbit;
                n.framing_error_flag = new_framing_error_flag;
                n.full = 1'b1;
                ev[srb_pkg::IRQ_RX] = 1'b1;
                ev[srb_pkg::IRQ_FRAMING_ERROR_FLAG] = new_framing_error_flag;
            end
        end
        // A new event outlasts a clear in the same cycle
        n.irq_st = (s.irq_st & ~w1c) | ev;

        case (wb_adr_i)
            srb_pkg::OFS_RX_CTRL: rdata = {s.spen, s.nine, s.single_receive_enable, s.continuous_receive_enable, s.address_detect_enable, s.framing_error_flag, s.overrun_error_flag, s.ninth};
            srb_pkg::OFS_TX_CTRL: rdata = {s.master, 1'b0, s.txon, s.sync, 1'b0, s.hs, 2'b00};
            srb_pkg::OFS_BAUD: rdata = s.divisor;
            srb_pkg::OFS_RX_DATA: rdata = s.rbuf;
            srb_pkg::OFS_IRQ_ST: rdata = {5'h00, s.irq_st};
            srb_pkg::OFS_IRQ_MASK: rdata = {5'h00, s.irq_mask};
            default: rdata = 8'h00;
        endcase
        if (n.ack)
        begin
            n.dat = rdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s <= srb_pkg::SRB_RST;
        end
        else
        begin
            s <= n;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = {24'h000000, s.dat};
    assign ck_out = s.ck_out;
    assign ck_oe_n = ~(s.spen & master);
    assign tx_active = s.txon & ~(s.sync & (s.single_receive_enable | s.continuous_receive_enable));
    assign irq = |(s.irq_st & s.irq_mask);

    chk_continuous_receive_enable_holds: assert property (@(posedge ref_clk) disable iff (srst)
        done && s.continuous_receive_enable && !wr |=> s.continuous_receive_enable && (s.single_receive_enable == $past(s.single_receive_enable)))
        else $error("continuous enable lost after a character");
    chk_framing_error_flag_load: assert property (@(posedge ref_clk) disable iff (srst)
        accept && !(s.full && !pop) |=> s.framing_error_flag == $past(new_framing_error_flag) && s.full)
        else $error("framing flag not refreshed on load");
    chk_overrun_error_flag_sticks: assert property (@(posedge ref_clk) disable iff (srst)
        s.overrun_error_flag && !continuous_receive_enable_clr |=> s.overrun_error_flag)
        else $error("overrun flag dropped without clearing enable");
    chk_brg_reload: assert property (@(posedge ref_clk) disable iff (srst)
        pre_tick && s.baud_generator == 8'h00 && !div_wr |=> s.baud_generator == $past(s.divisor))
        else $error("timer did not reload from divisor");
    chk_low_prescale: assert property (@(posedge ref_clk) disable iff (srst)
        !s.sync && !s.hs && !div_wr && s.pre == 2'h2 |=> s.pre == 2'h3 ##1 s.pre == 2'h0)
        else $error("low speed prescaler not divide by four");
    chk_sync_fast: assert property (@(posedge ref_clk) disable iff (srst)
        s.sync && s.pre == 2'h0 |-> pre_tick)
        else $error("sync mode used the high speed select");
    chk_slave_pin: assert property (@(posedge ref_clk) disable iff (srst)
        !master |-> ck_oe_n ##1 !s.ck_out)
        else $error("slave mode drives the shift clock");
    chk_div_clear: assert property (@(posedge ref_clk) disable iff (srst)
        div_wr |=> s.baud_generator == 8'h00 && s.pre == 2'h0)
        else $error("divisor write did not clear timer");
    chk_rx_over_tx: assert property (@(posedge ref_clk) disable iff (srst)
        s.sync && (s.single_receive_enable || s.continuous_receive_enable) |-> !tx_active)
        else $error("transmitter active over receive enable");
    chk_addr_filter: assert property (@(posedge ref_clk) disable iff (srst)
        done && s.nine && s.address_detect_enable && !nbit |=> !$rose(s.irq_st[srb_pkg::IRQ_RX]) && $stable(s.rbuf))
        else $error("address byte filter let a data byte in");
    chk_irq_level: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 irq == |($past(n.irq_st) & $past(n.irq_mask)))
        else $error("interrupt output disagrees with status and mask");
    chk_single_ends: assert property (@(posedge ref_clk) disable iff (srst)
        done && s.sync && !s.continuous_receive_enable |=> !s.single_receive_enable)
        else $error("single receive not cleared after a character");
    chk_continuous_receive_enable_rearms: assert property (@(posedge ref_clk) disable iff (srst)
        s.st == srb_pkg::ST_IDLE && en_s && s.continuous_receive_enable |=> s.st == srb_pkg::ST_DATA)
        else $error("continuous receive did not rearm");
    chk_framing_error_flag_steady: assert property (@(posedge ref_clk) disable iff (srst)
        !accept |=> $stable(s.framing_error_flag))
        else $error("framing flag changed without a load");
    chk_overrun_error_flag_set: assert property (@(posedge ref_clk) disable iff (srst)
        accept && s.full && !pop |=> s.overrun_error_flag && $stable(s.rbuf))
        else $error("overrun not flagged or buffer overwritten");
    chk_overrun_error_flag_clear: assert property (@(posedge ref_clk) disable iff (srst)
        continuous_receive_enable_clr && !accept |=> !s.overrun_error_flag)
        else $error("clearing continuous enable kept overrun flag");
    chk_brg_count: assert property (@(posedge ref_clk) disable iff (srst)
        pre_tick && s.baud_generator != 8'h00 && !div_wr |=> s.baud_generator == $past(s.baud_generator) - 8'h01)
        else $error("timer did not count down");
    chk_async_step: assert property (@(posedge ref_clk) disable iff (srst)
        s.st == srb_pkg::ST_DATA && en_a && brg_tick && s.os == srb_pkg::OS_LAST |=> s.bits == $past(s.bits) + 4'h1 && s.os == 4'h0)
        else $error("asynchronous bit not taken on sixteenth tick");
    chk_addr_accept: assert property (@(posedge ref_clk) disable iff (srst)
        done && s.nine && s.address_detect_enable && nbit && !(s.full && !pop) |=> s.full && s.rbuf == $past(char) && s.irq_st[srb_pkg::IRQ_RX])
        else $error("address byte not loaded");
    chk_event_wins: assert property (@(posedge ref_clk) disable iff (srst)
        ev[srb_pkg::IRQ_RX] |=> s.irq_st[srb_pkg::IRQ_RX])
        else $error("receive event lost");
    chk_ack_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (@(posedge ref_clk) disable iff (srst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
endmodule

/* srb_line_model.sv */
// Far end of the serial line: a behavioural asynchronous transmitter.
// Assumes the bench calls send_char from one thread, one frame at a time, on ref_clk.
`timescale 1ns/10ps
module srb_line_model
(
    // Clock
    input wire logic ref_clk,
    // Line, idle high as with a pull-up
    output logic rx_out
);
    initial rx_out = 1'b1;

    // Start, data LSB first, optional ninth bit, stop, then one idle bit
    task automatic send_char(input int bit_clks, input logic [8:0] d, input logic nine, input logic stop_val);
        logic [11:0] fr;
        int nb;
        begin
            nb = nine ? 12 : 11;
            fr = nine ? {1'b1, stop_val, d, 1'b0} : {2'b01, stop_val, d[7:0], 1'b0};
            @(posedge ref_clk);
            for (int i = 0; i < nb; i++)
            begin
                rx_out <= fr[i];
                repeat (bit_clks) @(posedge ref_clk);
            end
        end
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the serial receive block, register side over classic Wishbone.
// Assumes srb_line_model drives the data pin; the bench drives the external shift clock itself.
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] A_RXC = srb_pkg::OFS_RX_CTRL;
    localparam logic [7:0] A_TXC = srb_pkg::OFS_TX_CTRL;
    localparam logic [7:0] A_BD = srb_pkg::OFS_BAUD;
    localparam logic [7:0] A_DAT = srb_pkg::OFS_RX_DATA;
    localparam logic [7:0] A_IST = srb_pkg::OFS_IRQ_ST;
    localparam logic [7:0] A_IMK = srb_pkg::OFS_IRQ_MASK;
    logic ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_in, ck_in, ck_out, ck_oe_n, tx_active, irq;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int num_errors = 0;
    int n_compared = 0;
    int gap;

    srb_serial_rx srb_serial_rx_inst (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_in(rx_in), .ck_in(ck_in), .ck_out(ck_out), .ck_oe_n(ck_oe_n),
        .tx_active(tx_active), .irq(irq));
    srb_line_model srb_line_model_inst (.ref_clk(ref_clk), .rx_out(rx_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        begin
            $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            n_compared++;
            if (got !== exp)
            begin
                num_errors++;
                $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
            end
        end
    endtask

    // Classic cycle; ack and read data are taken at the rising edge that samples ack high
    task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d, output logic [31:0] q);
        int n;
        begin
            n = 0;
            @(posedge ref_clk);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= a;
            wb_dat_i <= {24'h000000, d};
            @(posedge ref_clk);
            while (wb_ack_o !== 1'b1)
            begin
                n++;
                if (n > 20)
                begin
                    num_errors++;
                    $display("CHECK FAILED bus ack expected 1 seen none");
                    report_and_stop();
                end
                @(posedge ref_clk);
            end
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            // Outputs of a landed write have settled by this edge
            @(negedge ref_clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        begin
            wb(a, 1'b1, d, q);
        end
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        begin
            wb(a, 1'b0, 8'h00, q);
            chk(what, exp, q);
        end
    endtask

    task automatic send(input int bc, input logic [8:0] d, input logic nine, input logic stp);
        begin
            srb_line_model_inst.send_char(bc, d, nine, stp);
        end
    endtask

    // Gap in clocks between two rising edges of the shift clock
    task automatic ck_period(output int g);
        int n, r0;
        logic prev;
        begin
            n = 0;
            r0 = -1;
            g = -1;
            @(negedge ref_clk);
            prev = ck_out;
            while (g < 0 && n < 300)
            begin
                @(negedge ref_clk);
                n++;
                if (ck_out === 1'b1 && prev === 1'b0)
                begin
                    if (r0 < 0)
                        r0 = n;
                    else
                        g = n - r0;
                end
                prev = ck_out;
            end
        end
    endtask

    task automatic test_regs();
        begin
            rdchk("rx ctrl reset", A_RXC, 32'h0);
            rdchk("tx ctrl reset", A_TXC, 32'h0);
            rdchk("divisor reset", A_BD, 32'h0);
            rdchk("mask reset", A_IMK, 32'h0);
            chk("clk enable idle", 32'h1, 32'(ck_oe_n));
            wr(8'h20, 8'hFF);
            rdchk("unmapped", 8'h20, 32'h0);
            wr(A_TXC, 8'hFF);
            rdchk("tx ctrl bits", A_TXC, 32'hB4);
            wr(A_TXC, 8'h00);
            wr(A_BD, 8'hA7);
            rdchk("divisor rw", A_BD, 32'hA7);
            $display("test_regs done");
        end
    endtask

    task automatic test_async();
        begin
            wr(A_BD, 8'h01);
            wr(A_IMK, 8'h01);
            wr(A_RXC, 8'h90);
            send(128, 9'h0A5, 1'b0, 1'b1);
            chk("irq raised", 32'h1, 32'(irq));
            rdchk("slow char", A_DAT, 32'hA5);
            rdchk("irq status", A_IST, 32'h1);
            wr(A_IST, 8'h01);
            chk("irq cleared", 32'h0, 32'(irq));
            send(128, 9'h03C, 1'b0, 1'b1);
            rdchk("second char", A_DAT, 32'h3C);
            wr(A_IST, 8'h07);
            $display("test_async done");
        end
    endtask

    task automatic test_fast();
        begin
            wr(A_TXC, 8'h04);
            wr(A_BD, 8'h03);
            wr(A_IMK, 8'h00);
            send(64, 9'h05A, 1'b0, 1'b1);
            chk("irq masked", 32'h0, 32'(irq));
            rdchk("fast char", A_DAT, 32'h5A);
            rdchk("status masked", A_IST, 32'h1);
            wr(A_IST, 8'h07);
            send(64, 9'h011, 1'b0, 1'b0);
            rdchk("framing set", A_RXC, 32'h94);
            rdchk("framing irq", A_IST, 32'h5);
            rdchk("framed char", A_DAT, 32'h11);
            send(64, 9'h022, 1'b0, 1'b1);
            rdchk("framing refreshed", A_RXC, 32'h90);
            rdchk("good char", A_DAT, 32'h22);
            wr(A_IST, 8'h07);
            $display("test_fast done");
        end
    endtask

    task automatic test_overrun();
        begin
            send(64, 9'h033, 1'b0, 1'b1);
            send(64, 9'h044, 1'b0, 1'b1);
            rdchk("overrun set", A_RXC, 32'h92);
            rdchk("overrun irq", A_IST, 32'h3);
            wr(A_RXC, 8'h80);
            rdchk("overrun cleared", A_RXC, 32'h80);
            rdchk("kept char", A_DAT, 32'h33);
            wr(A_IST, 8'h07);
            wr(A_RXC, 8'hD8);
            send(64, 9'h077, 1'b1, 1'b1);
            rdchk("data byte dropped", A_IST, 32'h0);
            send(64, 9'h1A8, 1'b1, 1'b1);
            rdchk("address kept", A_IST, 32'h1);
            rdchk("ninth bit", A_RXC, 32'hD9);
            rdchk("address byte", A_DAT, 32'hA8);
            wr(A_IST, 8'h07);
            $display("test_overrun done");
        end
    endtask

    task automatic test_sync();
        begin
            wr(A_RXC, 8'h80);
            wr(A_TXC, 8'hB4);
            chk("tx active", 32'h1, 32'(tx_active));
            chk("clk driven", 32'h0, 32'(ck_oe_n));
            wr(A_BD, 8'h02);
            wr(A_RXC, 8'h90);
            chk("rx over tx", 32'h0, 32'(tx_active));
            ck_period(gap);
            chk("sync period", 32'hC, gap);
            wr(A_BD, 8'h05);
            ck_period(gap);
            chk("new period", 32'h18, gap);
            wr(A_TXC, 8'h34);
            chk("slave clk released", 32'h1, 32'(ck_oe_n));
            wr(A_RXC, 8'h00);
            $display("test_sync done");
        end
    endtask

    task automatic test_single();
        logic [31:0] q;
        int n;
        begin
            wb(A_DAT, 1'b0, 8'h00, q);
            wr(A_IST, 8'h07);
            wr(A_TXC, 8'hB4);
            wr(A_RXC, 8'hA0);
            chk("single over tx", 32'h0, 32'(tx_active));
            n = 0;
            q = 32'h20;
            while (q[5] && n < 200)
            begin
                wb(A_RXC, 1'b0, 8'h00, q);
                n++;
            end
            chk("single receive ends", 32'h80, q);
            rdchk("single char", A_DAT, 32'hFF);
            chk("tx back", 32'h1, 32'(tx_active));
            wr(A_TXC, 8'h34);
            wr(A_RXC, 8'hA0);
            for (int i = 0; i < 8; i++)
            begin
                repeat (4) @(posedge ref_clk);
                ck_in <= 1'b1;
                repeat (4) @(posedge ref_clk);
                ck_in <= 1'b0;
            end
            repeat (8) @(posedge ref_clk);
            chk("slave pin idle", 32'h1, 32'(ck_oe_n));
            rdchk("slave single ends", A_RXC, 32'h80);
            rdchk("slave char", A_DAT, 32'hFF);
            wr(A_RXC, 8'h00);
            $display("test_single done");
        end
    endtask

    initial
    begin
        srst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        ck_in = 1'b0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        test_regs();
        test_async();
        test_fast();
        test_overrun();
        test_sync();
        test_single();
        report_and_stop();
    end
endmodule
